// File: eeprom_cycle_timer.sv
// Design decisions made here: the address-and-strobe port and the placing of the registers.
`timescale 1ns/100ps
`default_nettype none

module eeprom_cycle_timer #(
   parameter int PRESCALE = eeprom_timer_pkg::XTAL_PRESCALE
) (
   input  wire logic       core_clk,
   input  wire logic       sys_rst,
   input  wire logic [7:0] addr,
   input  wire logic [7:0] wdata,
   input  wire logic       wr_stb,
   input  wire logic       rd_stb,
   output var  logic [7:0] rdata,
   input  wire logic [3:0] latch_flags,
   input  wire logic       clk_stopped,
   input  wire logic       irq_in_service,
   input  wire logic       ext_irq_pending,
   input  wire logic       global_irq_enable,
   output var  logic       irq_req,
   output var  logic       irq_grant,
   output var  logic [3:0] erase_mask,
   output var  logic [3:0] write_mask,
   output var  logic       addr_advance,
   output var  logic       cycle_done
);

   localparam int RUN  = eeprom_timer_pkg::BIT_RUN;
   localparam int IEN  = eeprom_timer_pkg::BIT_IRQ_EN;
   localparam int FLG  = eeprom_timer_pkg::BIT_FLAG;
   localparam int PND  = eeprom_timer_pkg::BIT_PENDING;
   localparam int MMSB = eeprom_timer_pkg::MODE_MSB;
   localparam int MLSB = eeprom_timer_pkg::MODE_LSB;

   initial begin
      if (PRESCALE < 10) begin
         $error("eeprom_cycle_timer: PRESCALE must be at least 10");
      end
   end

   function automatic logic mode_starts_cycle(input logic [2:0] m);
      return (m == eeprom_timer_pkg::MODE_WRITE_PAGE) ||
             (m == eeprom_timer_pkg::MODE_ERASE_WRITE) ||
             (m == eeprom_timer_pkg::MODE_ERASE_PAGE);
   endfunction

   eeprom_timer_pkg::cyc_state_type state_ff;
   eeprom_timer_pkg::cyc_state_type nxt_state;

   logic       timer_run_ff;
   logic       timer_irq_enable_ff;
   logic       timer_flag_ff;
   logic [2:0] mode_ff;
   logic [7:0] reload_reg_ff;
   logic [7:0] down_counter_ff;
   logic [3:0] latch_ff;
   logic [7:0] rdata_ff;
   logic       irq_req_ff;
   logic       irq_grant_ff;
   logic [3:0] erase_mask_ff;
   logic [3:0] write_mask_ff;
   logic       addr_advance_ff;
   logic       cycle_done_ff;

   logic       ctrl_wr;
   logic       reload_wr;
   logic       busy;
   logic       start_cycle;
   logic       run_rise;
   logic       counting;
   logic       tick;
   logic       underflow;
   logic       end_cycle;
   logic       flag_hw_set;

   assign ctrl_wr     = wr_stb && (addr == eeprom_timer_pkg::OFS_CTRL);
   assign reload_wr   = wr_stb && (addr == eeprom_timer_pkg::OFS_RELOAD);
   assign busy        = (state_ff != eeprom_timer_pkg::cyc_idle);
   assign start_cycle = ctrl_wr && wdata[PND] && !busy && mode_starts_cycle(wdata[MMSB:MLSB]);
   assign run_rise    = ctrl_wr && wdata[RUN] && !timer_run_ff;
   assign counting    = timer_run_ff || busy;

   // prescaler freezes with the oscillator, runs on through idle mode
   step_prescaler #(
      .DIV (PRESCALE)
   ) u_prescaler (
      .core_clk (core_clk),
      .sys_rst  (sys_rst),
      .enable   (counting && !clk_stopped),
      .restart  (start_cycle || run_rise),
      .tick     (tick)
   );

   assign underflow   = tick && counting && (down_counter_ff == 8'h00);
   assign end_cycle   = underflow && busy &&
                        !((state_ff == eeprom_timer_pkg::cyc_erase) &&
                          (mode_ff == eeprom_timer_pkg::MODE_ERASE_WRITE));
   assign flag_hw_set = underflow && (!busy || end_cycle);

   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         eeprom_timer_pkg::cyc_idle: begin
            if (start_cycle) begin
               nxt_state = (wdata[MMSB:MLSB] == eeprom_timer_pkg::MODE_WRITE_PAGE) ?
                           eeprom_timer_pkg::cyc_write : eeprom_timer_pkg::cyc_erase;
            end
         end
         eeprom_timer_pkg::cyc_erase: begin
            if (underflow) begin
               nxt_state = (mode_ff == eeprom_timer_pkg::MODE_ERASE_WRITE) ?
                           eeprom_timer_pkg::cyc_write : eeprom_timer_pkg::cyc_idle;
            end
         end
         eeprom_timer_pkg::cyc_write: begin
            if (underflow) begin
               nxt_state = eeprom_timer_pkg::cyc_idle;
            end
         end
         default: begin
            nxt_state = eeprom_timer_pkg::cyc_idle;
         end
      endcase
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         state_ff <= eeprom_timer_pkg::cyc_idle;
      end else begin
         state_ff <= nxt_state;
      end
   end

   // control bits
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timer_run_ff        <= eeprom_timer_pkg::CTRL_RESET[RUN];
         timer_irq_enable_ff <= eeprom_timer_pkg::CTRL_RESET[IEN];
      end else if (ctrl_wr) begin
         timer_run_ff        <= wdata[RUN];
         timer_irq_enable_ff <= wdata[IEN];
      end
   end

   // mode bits lock while a cycle runs and clear at its end
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         mode_ff <= eeprom_timer_pkg::CTRL_RESET[MMSB:MLSB];
      end else if (end_cycle) begin
         mode_ff <= eeprom_timer_pkg::CTRL_RESET[MMSB:MLSB];
      end else if (ctrl_wr && !busy) begin
         mode_ff <= wdata[MMSB:MLSB];
      end
   end

   // hardware set wins over a software clear in the same cycle
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         timer_flag_ff <= eeprom_timer_pkg::CTRL_RESET[FLG];
      end else if (flag_hw_set) begin
         timer_flag_ff <= 1'b1;
      end else if (ctrl_wr) begin
         timer_flag_ff <= wdata[FLG];
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         reload_reg_ff <= eeprom_timer_pkg::RELOAD_RESET;
      end else if (reload_wr) begin
         reload_reg_ff <= wdata;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         down_counter_ff <= eeprom_timer_pkg::COUNT_RESET;
      end else if (start_cycle || run_rise) begin
         down_counter_ff <= reload_reg_ff;
      end else if (underflow && !end_cycle) begin
         down_counter_ff <= reload_reg_ff;
      end else if (tick && counting && (down_counter_ff != 8'h00)) begin
         down_counter_ff <= down_counter_ff - 8'h01;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         latch_ff <= 4'h0;
      end else if (start_cycle) begin
         latch_ff <= latch_flags;
      end
   end

   // page strobes: only flagged bytes are touched in each phase
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         erase_mask_ff <= 4'h0;
         write_mask_ff <= 4'h0;
      end else begin
         erase_mask_ff <= (nxt_state == eeprom_timer_pkg::cyc_erase) ?
                          (start_cycle ? latch_flags : latch_ff) : 4'h0;
         write_mask_ff <= (nxt_state == eeprom_timer_pkg::cyc_write) ?
                          (start_cycle ? latch_flags : latch_ff) : 4'h0;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         addr_advance_ff <= 1'b0;
         cycle_done_ff   <= 1'b0;
      end else begin
         addr_advance_ff <= end_cycle && (mode_ff != eeprom_timer_pkg::MODE_ERASE_PAGE);
         cycle_done_ff   <= end_cycle;
      end
   end

   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         irq_req_ff   <= 1'b0;
         irq_grant_ff <= 1'b0;
      end else begin
         irq_req_ff   <= timer_flag_ff;
         irq_grant_ff <= timer_flag_ff && timer_irq_enable_ff && global_irq_enable &&
                         !irq_in_service && !ext_irq_pending;
      end
   end

   // reads have no side effect on the count
   always_ff @(posedge core_clk) begin
      if (sys_rst) begin
         rdata_ff <= eeprom_timer_pkg::RDATA_IDLE;
      end else if (rd_stb) begin
         unique case (addr)
            eeprom_timer_pkg::OFS_CTRL:
               rdata_ff <= {timer_run_ff, timer_irq_enable_ff, timer_flag_ff, busy, mode_ff, 1'b0};
            eeprom_timer_pkg::OFS_RELOAD:
               rdata_ff <= reload_reg_ff;
            eeprom_timer_pkg::OFS_COUNT:
               rdata_ff <= down_counter_ff;
            default:
               rdata_ff <= eeprom_timer_pkg::RDATA_IDLE;
         endcase
      end else begin
         rdata_ff <= eeprom_timer_pkg::RDATA_IDLE;
      end
   end

   assign rdata        = rdata_ff;
   assign irq_req      = irq_req_ff;
   assign irq_grant    = irq_grant_ff;
   assign erase_mask   = erase_mask_ff;
   assign write_mask   = write_mask_ff;
   assign addr_advance = addr_advance_ff;
   assign cycle_done   = cycle_done_ff;

   default clocking cb @(posedge core_clk);
   endclocking
   default disable iff (sys_rst);

   a_start_loads_reload: assert property (
      start_cycle |=> busy && (down_counter_ff == $past(reload_reg_ff)))
      else $error("cycle start did not load the reload value");

   a_gp_underflow_reload: assert property (
      (underflow && !busy && !ctrl_wr) |=> timer_flag_ff && (down_counter_ff == $past(reload_reg_ff)))
      else $error("free-running underflow did not reload and flag");

   a_cycle_end_clears: assert property (
      end_cycle |=> !busy && timer_flag_ff && (mode_ff == 3'h0) ##1 cycle_done_ff == 1'b0)
      else $error("cycle end did not stop and clear");

   a_erase_no_advance: assert property (
      (end_cycle && (mode_ff == eeprom_timer_pkg::MODE_ERASE_PAGE)) |=> cycle_done_ff && !addr_advance_ff)
      else $error("erase page advanced the address");

   a_ew_second_phase: assert property (
      (underflow && (state_ff == eeprom_timer_pkg::cyc_erase) &&
       (mode_ff == eeprom_timer_pkg::MODE_ERASE_WRITE))
      |=> (state_ff == eeprom_timer_pkg::cyc_write) && !cycle_done_ff &&
          (down_counter_ff == $past(reload_reg_ff)))
      else $error("erase-then-write did not enter write phase");

   a_stopped_holds: assert property (
      (!counting && !start_cycle && !run_rise) |=> $stable(down_counter_ff))
      else $error("stopped counter changed");

   a_freeze_holds: assert property (
      (clk_stopped && !start_cycle && !run_rise) |=> $stable(down_counter_ff) && !tick)
      else $error("counter moved with clock stopped");

   a_grant_gating: assert property (
      irq_grant_ff |-> $past(timer_flag_ff && timer_irq_enable_ff && global_irq_enable &&
                             !irq_in_service && !ext_irq_pending))
      else $error("interrupt granted without all conditions");

   a_sw_flag_set: assert property (
      (ctrl_wr && wdata[FLG]) |=> timer_flag_ff ##1 irq_req_ff)
      else $error("software flag set did not request interrupt");

   a_ctrl_bit0_zero: assert property (
      $past(rd_stb && (addr == eeprom_timer_pkg::OFS_CTRL)) |-> (rdata_ff[0] == 1'b0) &&
                                                          (rdata_ff[PND] == $past(busy)))
      else $error("control readback wrong");

   a_erase_mask_flags: assert property (
      (state_ff == eeprom_timer_pkg::cyc_erase) |-> (erase_mask_ff == latch_ff) && (write_mask_ff == 4'h0))
      else $error("erase touched unflagged bytes");

   c_gp_underflow:  cover property (underflow && !busy);
   c_ew_phase_swap: cover property ((state_ff == eeprom_timer_pkg::cyc_erase) ##1
                                    (state_ff == eeprom_timer_pkg::cyc_write));
   c_erase_done:    cover property (end_cycle && (mode_ff == eeprom_timer_pkg::MODE_ERASE_PAGE));
   c_sw_irq_grant:  cover property ((ctrl_wr && wdata[FLG] && !timer_flag_ff) ##[1:3] irq_grant_ff);

endmodule

`default_nettype wire

// File: eeprom_cycle_timer_tb_top.sv
`timescale 1ns/100ps
`default_nettype none

module eeprom_cycle_timer_tb_top;
   localparam int P   = 10;
   localparam int TOL = 3;

   logic       core_clk;
   logic       sys_rst;
   logic [7:0] addr;
   logic [7:0] wdata;
   logic       wr_stb;
   logic       rd_stb;
   logic [7:0] rdata;
   logic [3:0] latch_flags;
   logic       clk_stopped;
   logic       irq_in_service;
   logic       ext_irq_pending;
   logic       global_irq_enable;
   logic       irq_req;
   logic       irq_grant;
   logic [3:0] erase_mask;
   logic [3:0] write_mask;
   logic       addr_advance;
   logic       cycle_done;
   int         failures;
   int         n_checks;
   int         cyc = 0;
   logic [7:0] d;
   logic [7:0] v1;
   logic [7:0] v2;
   int         t0;

   eeprom_cycle_timer #(.PRESCALE(P)) i_eeprom_cycle_timer (
      .core_clk(core_clk), .sys_rst(sys_rst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
      .rdata(rdata), .latch_flags(latch_flags), .clk_stopped(clk_stopped), .irq_in_service(irq_in_service),
      .ext_irq_pending(ext_irq_pending), .global_irq_enable(global_irq_enable), .irq_req(irq_req),
      .irq_grant(irq_grant), .erase_mask(erase_mask), .write_mask(write_mask), .addr_advance(addr_advance),
      .cycle_done(cycle_done));

   initial begin
      core_clk = 1'b0;
      forever #20 core_clk = ~core_clk;
   end

   always @(posedge core_clk) begin
      cyc <= cyc + 1;
   end

   task automatic stop_test();
      $display("checks %0d failures %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk_val(input logic [7:0] got, input logic [7:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // elapsed cycles against an interval, allowing for pipeline latency
   task automatic chk_time(input int got, input int exp);
      n_checks++;
      if (got < exp - TOL || got > exp + TOL) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] v);
      @(posedge core_clk);
      addr <= a;
      wdata <= v;
      wr_stb <= 1'b1;
      @(posedge core_clk);
      wr_stb <= 1'b0;
   endtask

   task automatic rd(input logic [7:0] a, output logic [7:0] v);
      @(posedge core_clk);
      addr <= a;
      rd_stb <= 1'b1;
      @(posedge core_clk);
      rd_stb <= 1'b0;
      #1;
      v = rdata;
   endtask

   function automatic logic exp_grant(input logic [3:0] g);
      return g[3] & g[2] & ~g[1] & ~g[0];
   endfunction

   function automatic logic [7:0] ctrl_busy(input logic [2:0] mode);
      return {4'h1, mode, 1'b0};
   endfunction

   task automatic mem_cycle(input logic [2:0] mode);
      logic [7:0] r;
      logic [3:0] f;
      logic [7:0] q;
      int         n;
      r = 8'($urandom_range(1, 4));
      f = 4'($urandom_range(1, 15));
      latch_flags <= f;
      wr(eeprom_timer_pkg::OFS_RELOAD, r);
      wr(eeprom_timer_pkg::OFS_CTRL, ctrl_busy(mode));
      t0 = cyc;
      @(posedge core_clk);
      #1;
      chk_val({4'h0, erase_mask}, (mode == eeprom_timer_pkg::MODE_WRITE_PAGE) ? 8'h00 : {4'h0, f});
      chk_val({4'h0, write_mask}, (mode == eeprom_timer_pkg::MODE_WRITE_PAGE) ? {4'h0, f} : 8'h00);
      // a second start with an invalid mode while busy must leave the cycle alone
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h12);
      rd(eeprom_timer_pkg::OFS_CTRL, q);
      chk_val(q, ctrl_busy(mode));
      rd(eeprom_timer_pkg::OFS_COUNT, q);
      chk_val(q, r);
      if (mode == eeprom_timer_pkg::MODE_ERASE_WRITE) begin
         n = 0;
         do begin
            @(posedge core_clk);
            #1;
            n++;
         end while (write_mask === 4'h0 && n < 500);
         chk_time(cyc - t0, (int'(r) + 1) * P);
         chk_val({4'h0, erase_mask}, 8'h00);
         chk_val({4'h0, write_mask}, {4'h0, f});
         t0 = cyc;
      end
      n = 0;
      do begin
         @(posedge core_clk);
         #1;
         n++;
      end while (cycle_done !== 1'b1 && n < 500);
      chk_time(cyc - t0, (int'(r) + 1) * P);
      chk_val({7'h0, addr_advance}, (mode == eeprom_timer_pkg::MODE_ERASE_PAGE) ? 8'h00 : 8'h01);
      @(posedge core_clk);
      #1;
      chk_val({7'h0, irq_req}, 8'h01);
      rd(eeprom_timer_pkg::OFS_CTRL, q);
      chk_val(q, 8'h20);
      repeat (2 * P) @(posedge core_clk);
      rd(eeprom_timer_pkg::OFS_COUNT, q);
      chk_val(q, 8'h00);
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h00);
   endtask

   initial begin
      repeat (20000) @(posedge core_clk);
      failures++;
      stop_test();
   end

   initial begin
      failures = 0;
      n_checks = 0;
      sys_rst = 1'b1;
      addr = 8'h00;
      wdata = 8'h00;
      wr_stb = 1'b0;
      rd_stb = 1'b0;
      latch_flags = 4'h0;
      clk_stopped = 1'b0;
      irq_in_service = 1'b0;
      ext_irq_pending = 1'b0;
      global_irq_enable = 1'b0;
      void'($urandom(31262));
      repeat (8) @(posedge core_clk);
      sys_rst <= 1'b0;
      for (int i = 0; i < 8; i++) begin
         rd(8'h04 + 8'(i % 4), d);
         chk_val(d, 8'h00);
      end
      v1 = 8'($urandom);
      wr(eeprom_timer_pkg::OFS_RELOAD, v1);
      wr(eeprom_timer_pkg::OFS_COUNT, 8'hff);
      wr(8'h07, 8'($urandom));
      rd(eeprom_timer_pkg::OFS_RELOAD, d);
      chk_val(d, v1);
      rd(eeprom_timer_pkg::OFS_COUNT, d);
      chk_val(d, 8'h00);
      rd(8'h07, d);
      chk_val(d, 8'h00);
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h0f);
      rd(eeprom_timer_pkg::OFS_CTRL, d);
      chk_val(d, 8'h0e);
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h00);
      mem_cycle(eeprom_timer_pkg::MODE_ERASE_PAGE);
      mem_cycle(eeprom_timer_pkg::MODE_WRITE_PAGE);
      mem_cycle(eeprom_timer_pkg::MODE_ERASE_WRITE);
      for (int i = 0; i < 16; i++) begin
         @(posedge core_clk);
         irq_in_service <= i[0];
         ext_irq_pending <= i[1];
         global_irq_enable <= i[2];
         wr(eeprom_timer_pkg::OFS_CTRL, {1'b0, i[3], 1'b1, 5'h00});
         repeat (2) @(posedge core_clk);
         #1;
         chk_val({7'h0, irq_req}, 8'h01);
         chk_val({7'h0, irq_grant}, {7'h0, exp_grant(4'(i))});
         wr(eeprom_timer_pkg::OFS_CTRL, 8'h00);
      end
      // free running with reload 4: period is five steps
      wr(eeprom_timer_pkg::OFS_RELOAD, 8'h04);
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h80);
      do begin
         @(posedge core_clk);
         #1;
      end while (irq_req !== 1'b1 && cyc < 5000);
      t0 = cyc;
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h80);
      do begin
         @(posedge core_clk);
         #1;
      end while (irq_req !== 1'b1 && cyc < 5000);
      chk_time(cyc - t0, 5 * P);
      rd(eeprom_timer_pkg::OFS_COUNT, d);
      chk_val(d, 8'h04);
      repeat (2 * P) @(posedge core_clk);
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h00);
      rd(eeprom_timer_pkg::OFS_COUNT, v1);
      chk_val(v1, 8'h02);
      repeat (3 * P) @(posedge core_clk);
      rd(eeprom_timer_pkg::OFS_COUNT, v2);
      chk_val(v2, v1);
      rd(eeprom_timer_pkg::OFS_CTRL, d);
      chk_val(d, 8'h00);
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h80);
      rd(eeprom_timer_pkg::OFS_COUNT, d);
      chk_val(d, 8'h04);
      repeat (P + 3) @(posedge core_clk);
      clk_stopped <= 1'b1;
      rd(eeprom_timer_pkg::OFS_COUNT, v1);
      repeat (3 * P) @(posedge core_clk);
      rd(eeprom_timer_pkg::OFS_COUNT, v2);
      chk_val(v2, v1);
      @(posedge core_clk);
      clk_stopped <= 1'b0;
      repeat (P + 2) @(posedge core_clk);
      rd(eeprom_timer_pkg::OFS_COUNT, v2);
      chk_val(v2, v1 - 8'h01);
      wr(eeprom_timer_pkg::OFS_CTRL, 8'h00);
      stop_test();
   end
endmodule

`default_nettype wire

// File: eeprom_timer_pkg.sv
package eeprom_timer_pkg;

   // register offsets
   localparam logic [7:0] OFS_CTRL   = 8'h04;
   localparam logic [7:0] OFS_RELOAD = 8'h05;
   localparam logic [7:0] OFS_COUNT  = 8'h06;

   // control register field positions
   localparam int BIT_RUN      = 7;
   localparam int BIT_IRQ_EN   = 6;
   localparam int BIT_FLAG     = 5;
   localparam int BIT_PENDING  = 4;
   localparam int MODE_MSB     = 3;
   localparam int MODE_LSB     = 1;
   localparam int MODE_WIDTH   = 3;

   // mode select codes {mode_sel_bit3, mode_sel_bit2, mode_sel_bit1}
   localparam logic [2:0] MODE_WRITE_PAGE = 3'h2;
   localparam logic [2:0] MODE_ERASE_WRITE = 3'h4;
   localparam logic [2:0] MODE_ERASE_PAGE = 3'h7;

   // reset values
   localparam logic [7:0] CTRL_RESET   = 8'h00;
   localparam logic [7:0] RELOAD_RESET = 8'h00;
   localparam logic [7:0] COUNT_RESET  = 8'h00;
   localparam logic [7:0] RDATA_IDLE   = 8'h00;

   // timing: one counter step per prescale period of crystal clocks
   localparam int XTAL_PRESCALE = 480;
   localparam int INTERVAL_MS   = 5;

   // interval reload examples for common crystals, count minus one
   localparam logic [7:0] RELOAD_AT_3M58  = 8'h25;
   localparam logic [7:0] RELOAD_AT_10M74 = 8'h6f;

   typedef enum logic [1:0] {
      cyc_idle,
      cyc_erase,
      cyc_write
   } cyc_state_type;

endpackage

// File: step_prescaler.sv
`timescale 1ns/100ps
`default_nettype none

module step_prescaler #(
   parameter int DIV = 480
) (
   input  wire logic core_clk,
   input  wire logic sys_rst,
   input  wire logic enable,
   input  wire logic restart,
   output var  logic tick
);

   localparam int CW = $clog2(DIV);
   localparam logic [CW-1:0] LAST = CW'(DIV - 1);

   logic [CW-1:0] phase_ff;

   initial begin
      if (DIV < 10) begin
         $error("step_prescaler: DIV must be at least 10");
      end
   end

   // restart aligns the first step to a full period; freezes while disabled
   always_ff @(posedge core_clk) begin
      if (sys_rst || restart) begin
         phase_ff <= '0;
      end else if (enable) begin
         phase_ff <= (phase_ff == LAST) ? '0 : phase_ff + CW'(1);
      end
   end

   // step lands on the wrap edge itself, so a stopped clock can never let a late step through
   assign tick = enable && (phase_ff == LAST);

   a_tick_spacing: assert property (@(posedge core_clk) disable iff (sys_rst)
      tick |=> !tick [*8]) else $error("prescaler steps too close together");

endmodule

`default_nettype wire
